// ### include/led_fault_defs.vh
`ifndef LED_FAULT_DEFS_VH
`define LED_FAULT_DEFS_VH

// ****************************************************************
// channel and word widths
// ****************************************************************
`define CH_NUM 16
`define CH_MSB 15
`define APB_AW 8
`define APB_DW 32

// ****************************************************************
// register byte addresses
// ****************************************************************
`define ADDR_CTRL 8'h00
`define ADDR_STATUS_WORD 8'h04
`define ADDR_ONOFF 8'h08
`define ADDR_IRQ_STAT 8'h0C
`define ADDR_IRQ_MASK 8'h10
`define ADDR_SHIFT 8'h14

// ****************************************************************
// field positions and reset values
// ****************************************************************
`define CTRL_FORCE_OFF_BIT 0
`define CTRL_RESET 1'h0
`define IRQ_BITS 3
`define IRQ_CAPTURE_BIT 0
`define IRQ_WARN_BIT 1
`define IRQ_STROBE_BIT 2
`define IRQ_RESET 3'h0
`define WORD_RESET 16'h0000
`define STATUS_WARN_BIT 16

`endif

// ### tb/led_ctrl_model.sv
`timescale 1ns/100ps
// ****
// display controller on the link
// ****
module led_ctrl_model (
   input wire ref_clk,
   input wire serial_data_out,
   output reg shift_clk,
   output reg serial_data_in,
   output reg latch_strobe,
   output reg blank
);
   // all link pins low at reset release so no false edge is seen
   initial begin
      shift_clk = 1'b0;
      serial_data_in = 1'b0;
      latch_strobe = 1'b0;
      blank = 1'b0;
   end
   task tick(input int n);
      repeat (n) @(posedge ref_clk);
   endtask
   // msb first so bit n lands at chain bit n; read taken before each rise
   task xfer(input logic [15:0] w, output logic [15:0] rd);
      for (int i = 15; i >= 0; i--) begin
         serial_data_in <= w[i];
         tick(3);
         @(negedge ref_clk) rd[i] = serial_data_out;
         tick(1);
         shift_clk <= 1'b1;
         tick(4);
         shift_clk <= 1'b0;
      end
      // a released line must not keep the last bit
      serial_data_in <= ~w[0];
      tick(4);
   endtask
   task latch;
      latch_strobe <= 1'b1;
      tick(4);
      latch_strobe <= 1'b0;
      tick(8);
   endtask
   task set_blank(input logic v);
      blank <= v;
      tick(8);
   endtask
endmodule // led_ctrl_model

// ### tb/led_fault_asserts.sv
`timescale 1ns/100ps
`include "led_fault_defs.vh"
// ****
// port checks
// ****
module led_fault_asserts (
   input wire ref_clk,
   input wire resetn,
   input wire shift_clk,
   input wire latch_strobe,
   input wire blank,
   input wire overtemp_warning,
   input wire psel,
   input wire penable,
   input wire pready,
   input wire pslverr,
   input wire [`APB_DW-1:0] prdata,
   input wire serial_data_out,
   input wire [`CH_MSB:0] sink_output
);
   // cycles since a pin that may move the serial output was high
   reg [3:0] quiet_ff;
   wire [3:0] nxt_quiet = (shift_clk | latch_strobe) ? 4'h0 : quiet_ff + {3'h0, ~&quiet_ff};
   always @(posedge ref_clk) begin
      if (!resetn) quiet_ff <= 4'h0;
      else quiet_ff <= nxt_quiet;
   end
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!resetn);
   sequence s_setup; psel && !penable; endsequence
   sequence s_steady; (overtemp_warning && !blank && !latch_strobe && !psel) [*8]; endsequence
   property p_setup_ready; s_setup |=> pready; endproperty
   a_setup_ready: assert property (p_setup_ready) else $error("no ready");
   property p_idle_ready; !psel |=> !pready; endproperty
   a_idle_ready: assert property (p_idle_ready) else $error("stray ready");
   property p_ready_once; pready |=> !pready; endproperty
   a_ready_once: assert property (p_ready_once) else $error("ready held");
   property p_err_data; pslverr |-> pready && prdata == 32'h0; endproperty
   a_err_data: assert property (p_err_data) else $error("bad error reply");
   property p_idle_data; !pready |-> prdata == 32'h0; endproperty
   a_idle_data: assert property (p_idle_data) else $error("idle read data");
   property p_blank_off; blank [*6] |-> sink_output == 16'h0000; endproperty
   a_blank_off: assert property (p_blank_off) else $error("output on in blank");
   property p_serial_data_out_cause; $changed(serial_data_out) |-> quiet_ff < 4'h6; endproperty
   a_serial_data_out_cause: assert property (p_serial_data_out_cause) else $error("stray serial_data_out");
   property p_warn_hold; s_steady |-> $stable(sink_output); endproperty
   a_warn_hold: assert property (p_warn_hold) else $error("output moved");
endmodule // led_fault_asserts
bind led_fault_status_readout led_fault_asserts chk (.ref_clk(ref_clk), .resetn(resetn),
   .shift_clk(shift_clk), .latch_strobe(latch_strobe), .blank(blank), .psel(psel),
   .overtemp_warning(overtemp_warning), .penable(penable), .pready(pready),
   .pslverr(pslverr), .prdata(prdata), .serial_data_out(serial_data_out),
   .sink_output(sink_output));

// ### tb/tb.sv
`timescale 1ns/100ps
`include "led_fault_defs.vh"
// ****
// self-checking bench
// ****
module tb;
   reg ref_clk = 1'b0;
   reg resetn;
   reg psel;
   reg penable;
   reg pwrite;
   reg [7:0] paddr;
   reg [31:0] pwdata;
   reg [15:0] cmp;
   reg hot;
   wire shift_clk, serial_data_in, latch_strobe, blank, serial_data_out, irq, pready, pslverr;
   wire [15:0] sink_output;
   wire [31:0] prdata;
   logic [31:0] q;
   logic serr;
   logic [15:0] r;
   int err_total = 0;
   int num_checks = 0;
   always #10 ref_clk = ~ref_clk;
   led_ctrl_model ctl (.ref_clk(ref_clk), .serial_data_out(serial_data_out),
      .shift_clk(shift_clk), .serial_data_in(serial_data_in),
      .latch_strobe(latch_strobe), .blank(blank));
   led_fault_status_readout uut (.ref_clk(ref_clk), .resetn(resetn), .shift_clk(shift_clk),
      .serial_data_in(serial_data_in), .latch_strobe(latch_strobe), .blank(blank),
      .open_detect_cmp(cmp), .overtemp_warning(hot), .serial_data_out(serial_data_out),
      .sink_output(sink_output), .irq(irq), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
   task chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         err_total++;
         $display("Error %s expected %h seen %h", nm, exp, got);
      end
   endtask
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge ref_clk) penable <= 1'b1;
      n = 0;
      do begin @(posedge ref_clk); n++; end while (pready !== 1'b1 && n < 9);
      if (pready !== 1'b1) begin
         err_total++;
         $display("Error apb pready expected 1 seen %b", pready);
      end
      q = prdata;
      serr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      // one idle edge keeps the next call from reassigning psel in this step
      @(posedge ref_clk);
   endtask
   task t_regs;
      for (int a = 0; a < 24; a += 4) begin
         apb(1'b0, a[7:0], 32'h0);
         chk("reset reg", q, 32'h0);
      end
      apb(1'b0, 8'h18, 32'h0);
      chk("slverr", {31'h0, serr}, 32'h1);
      $display("regs done");
   endtask
   task t_lit;
      ctl.xfer(16'hA5C3, r);
      ctl.latch;
      chk("sink", {16'h0, sink_output}, 32'hA5C3);
      apb(1'b1, `ADDR_CTRL, 32'h1);
      ctl.tick(3);
      chk("forced off", {16'h0, sink_output}, 32'h0);
      apb(1'b1, `ADDR_CTRL, 32'h0);
      $display("lit done");
   endtask
   task t_open;
      cmp <= 16'h00FF;
      apb(1'b1, `ADDR_IRQ_MASK, 32'h1);
      ctl.tick(60); // on well over one microsecond
      ctl.set_blank(1'b1); // status read only after a blank rise
      cmp <= 16'hFFFF;
      chk("irq", {31'h0, irq}, 32'h1);
      ctl.tick(8);
      apb(1'b0, `ADDR_STATUS_WORD, 32'h0);
      chk("status", q, 32'h00C3);
      apb(1'b1, `ADDR_IRQ_STAT, 32'h1);
      apb(1'b0, `ADDR_IRQ_STAT, 32'h0);
      chk("irq stat", q, 32'h4);
      ctl.latch;
      ctl.xfer(16'h0F0F, r);
      chk("readout", {16'h0, r}, 32'h00C3);
      ctl.latch;
      apb(1'b0, `ADDR_SHIFT, 32'h0);
      chk("chain", q, 32'h00C3);
      ctl.set_blank(1'b0);
      chk("sink2", {16'h0, sink_output}, 32'h0F0F);
      $display("open done");
   endtask
   task t_hot;
      hot <= 1'b1;
      cmp <= 16'h0000;
      apb(1'b1, `ADDR_IRQ_MASK, 32'h2);
      ctl.tick(60);
      chk("hot sink", {16'h0, sink_output}, 32'h0F0F);
      ctl.set_blank(1'b1);
      chk("irq warn", {31'h0, irq}, 32'h1);
      apb(1'b0, `ADDR_STATUS_WORD, 32'h0);
      chk("warn status", q, 32'h1FFFF);
      apb(1'b1, `ADDR_IRQ_STAT, 32'h7);
      chk("irq clear", {31'h0, irq}, 32'h0);
      hot <= 1'b0;
      cmp <= 16'h0003;
      ctl.set_blank(1'b0);
      ctl.tick(60);
      ctl.set_blank(1'b1);
      apb(1'b0, `ADDR_STATUS_WORD, 32'h0);
      chk("cool status", q, 32'h0003);
      $display("hot done");
   endtask
   task results;
      $display("checks %0d mismatches %0d", num_checks, err_total);
      if (err_total == 0 && num_checks > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   initial begin
      resetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
      cmp = 16'h0000;
      hot = 1'b0;
      repeat (16) @(posedge ref_clk);
      resetn <= 1'b1;
      @(posedge ref_clk);
      t_regs;
      t_lit;
      t_open;
      t_hot;
      results;
   end
   // the tests need about 600 cycles
   initial begin
      #200000;
      err_total++;
      results;
   end
endmodule // tb

// ### verilog/fault_capture.v
`timescale 1ns/100ps
`include "led_fault_defs.vh"

// ****************************************************************
// open detection accumulation and status latch
// ****************************************************************
module fault_capture (
   input wire ref_clk,
   input wire resetn,
   input wire blank_level,
   input wire blank_rise,
   input wire [`CH_MSB:0] onoff,
   input wire [`CH_MSB:0] open_cmp,
   input wire overtemp_warning,
   output wire [`CH_MSB:0] fault_status_word,
   output wire warn_latched
);

   reg [`CH_MSB:0] open_led_flag_ff;
   reg [`CH_MSB:0] status_ff;
   reg warn_ff;
   reg [`CH_MSB:0] nxt_open_led_flag;

   // flags only collect on channels set in the on/off latch while blanking is low
   always @* begin
      nxt_open_led_flag = open_led_flag_ff;
      if (blank_rise)
         nxt_open_led_flag = `WORD_RESET;
      else if (!blank_level)
         nxt_open_led_flag = open_led_flag_ff | (onoff & open_cmp);
   end

   always @(posedge ref_clk) begin
      if (!resetn) begin
         open_led_flag_ff <= `WORD_RESET;
         status_ff <= `WORD_RESET;
         warn_ff <= 1'b0;
      end else begin
         open_led_flag_ff <= nxt_open_led_flag;
         if (blank_rise) begin
            // latched content holds until the next rising edge of blanking
            warn_ff <= overtemp_warning;
            if (overtemp_warning)
               status_ff <= {`CH_NUM{1'b1}};
            else
               status_ff <= open_led_flag_ff;
         end
      end
   end

   assign fault_status_word = status_ff;
   assign warn_latched = warn_ff;

endmodule // fault_capture

// ### verilog/led_fault_status_readout.v
// The register offsets and the APB slave port were chosen for this implementation.
`timescale 1ns/100ps
`include "led_fault_defs.vh"

module led_fault_status_readout (
   input wire ref_clk,
   input wire resetn,
   input wire shift_clk,
   input wire serial_data_in,
   input wire latch_strobe,
   input wire blank,
   input wire [`CH_MSB:0] open_detect_cmp,
   input wire overtemp_warning,
   output wire serial_data_out,
   output wire [`CH_MSB:0] sink_output,
   output wire irq,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [`APB_AW-1:0] paddr,
   input wire [`APB_DW-1:0] pwdata,
   output wire [`APB_DW-1:0] prdata,
   output wire pready,
   output wire pslverr
);

   // ****************************************************************
   // pin synchronisers
   // ****************************************************************
   wire [3:0] pin_level;
   wire [3:0] pin_rise;
   wire [`CH_MSB:0] cmp_level;
   wire [0:0] warn_level;
   wire shift_rise;
   wire latch_rise;
   wire blank_rise;
   wire blank_level;
   wire sin_level;

   // data pin shares the clock pin's delay so the sample stays aligned
   pin_sync #(.WIDTH(4)) u_ctl_sync (
      .ref_clk(ref_clk),
      .resetn(resetn),
      .pin_in({blank, latch_strobe, serial_data_in, shift_clk}),
      .level(pin_level),
      .rise(pin_rise)
   );

   pin_sync #(.WIDTH(`CH_NUM)) u_cmp_sync (
      .ref_clk(ref_clk),
      .resetn(resetn),
      .pin_in(open_detect_cmp),
      .level(cmp_level),
      .rise()
   );

   pin_sync #(.WIDTH(1)) u_warn_sync (
      .ref_clk(ref_clk),
      .resetn(resetn),
      .pin_in(overtemp_warning),
      .level(warn_level),
      .rise()
   );

   assign shift_rise = pin_rise[0];
   assign sin_level = pin_level[1];
   assign latch_rise = pin_rise[2];
   assign blank_level = pin_level[3];
   assign blank_rise = pin_rise[3];

   // ****************************************************************
   // state
   // ****************************************************************
   reg [`CH_MSB:0] shift_ff;
   reg [`CH_MSB:0] onoff_ff;
   reg [`CH_MSB:0] sink_ff;
   reg serial_data_out_ff;
   reg force_off_ff;
   reg [`IRQ_BITS-1:0] irq_stat_ff;
   reg [`IRQ_BITS-1:0] irq_mask_ff;
   reg irq_ff;
   reg [`APB_DW-1:0] prdata_ff;
   reg pready_ff;
   reg pslverr_ff;

   reg [`CH_MSB:0] nxt_shift;
   reg [`CH_MSB:0] nxt_onoff;
   reg [`CH_MSB:0] nxt_sink;
   reg [`IRQ_BITS-1:0] nxt_irq_stat;
   reg [`IRQ_BITS-1:0] irq_event;
   reg [`APB_DW-1:0] nxt_prdata;
   reg nxt_pslverr;

   wire [`CH_MSB:0] fault_status_word;
   wire warn_latched;

   // ****************************************************************
   // fault capture
   // ****************************************************************
   fault_capture u_capture (
      .ref_clk(ref_clk),
      .resetn(resetn),
      .blank_level(blank_level),
      .blank_rise(blank_rise),
      .onoff(onoff_ff),
      .open_cmp(cmp_level),
      .overtemp_warning(warn_level[0]),
      .fault_status_word(fault_status_word),
      .warn_latched(warn_latched)
   );

   // ****************************************************************
   // shift chain and on/off latch
   // ****************************************************************
   always @* begin
      nxt_shift = shift_ff;
      nxt_onoff = onoff_ff;
      // a strobe in the same cycle as a shift edge wins: the load replaces the chain
      if (latch_rise) begin
         nxt_onoff = shift_ff;
         nxt_shift = fault_status_word;
      end else if (shift_rise) begin
         nxt_shift = {shift_ff[`CH_MSB-1:0], sin_level};
      end
   end

   // outputs follow the latch only while blanking is low; warning has no say
   always @* begin
      if (blank_level || force_off_ff)
         nxt_sink = `WORD_RESET;
      else
         nxt_sink = nxt_onoff;
   end

   always @(posedge ref_clk) begin
      if (!resetn) begin
         shift_ff <= `WORD_RESET;
         onoff_ff <= `WORD_RESET;
         sink_ff <= `WORD_RESET;
         serial_data_out_ff <= 1'b0;
      end else begin
         shift_ff <= nxt_shift;
         onoff_ff <= nxt_onoff;
         sink_ff <= nxt_sink;
         serial_data_out_ff <= nxt_shift[`CH_MSB];
      end
   end

   // ****************************************************************
   // interrupt events
   // ****************************************************************
   wire wr_access;
   wire setup_phase;

   assign setup_phase = psel && !penable;
   assign wr_access = psel && penable && pready_ff && pwrite;

   always @* begin
      irq_event = `IRQ_RESET;
      irq_event[`IRQ_CAPTURE_BIT] = blank_rise;
      irq_event[`IRQ_WARN_BIT] = blank_rise && warn_level[0];
      irq_event[`IRQ_STROBE_BIT] = latch_rise;
      nxt_irq_stat = irq_stat_ff;
      if (wr_access && paddr == `ADDR_IRQ_STAT)
         nxt_irq_stat = irq_stat_ff & ~pwdata[`IRQ_BITS-1:0];
      // a new event wins over a clear in the same cycle
      nxt_irq_stat = nxt_irq_stat | irq_event;
   end

   // ****************************************************************
   // apb slave: one wait-free access phase, data prepared at setup
   // ****************************************************************
   always @* begin
      nxt_prdata = {`APB_DW{1'b0}};
      nxt_pslverr = 1'b0;
      case (paddr)
         `ADDR_CTRL: nxt_prdata[`CTRL_FORCE_OFF_BIT] = force_off_ff;
         `ADDR_STATUS_WORD: nxt_prdata[`STATUS_WARN_BIT:0] = {warn_latched, fault_status_word};
         `ADDR_ONOFF: nxt_prdata[`CH_MSB:0] = onoff_ff;
         `ADDR_IRQ_STAT: nxt_prdata[`IRQ_BITS-1:0] = irq_stat_ff;
         `ADDR_IRQ_MASK: nxt_prdata[`IRQ_BITS-1:0] = irq_mask_ff;
         `ADDR_SHIFT: nxt_prdata[`CH_MSB:0] = shift_ff;
         default: nxt_pslverr = 1'b1;
      endcase
   end

   always @(posedge ref_clk) begin
      if (!resetn) begin
         force_off_ff <= `CTRL_RESET;
         irq_stat_ff <= `IRQ_RESET;
         irq_mask_ff <= `IRQ_RESET;
         irq_ff <= 1'b0;
         prdata_ff <= {`APB_DW{1'b0}};
         pready_ff <= 1'b0;
         pslverr_ff <= 1'b0;
      end else begin
         irq_stat_ff <= nxt_irq_stat;
         irq_ff <= |(nxt_irq_stat & irq_mask_ff);
         pready_ff <= setup_phase;
         if (setup_phase) begin
            prdata_ff <= pwrite ? {`APB_DW{1'b0}} : nxt_prdata;
            pslverr_ff <= nxt_pslverr;
         end else begin
            prdata_ff <= {`APB_DW{1'b0}};
            pslverr_ff <= 1'b0;
         end
         if (wr_access && paddr == `ADDR_CTRL)
            force_off_ff <= pwdata[`CTRL_FORCE_OFF_BIT];
         if (wr_access && paddr == `ADDR_IRQ_MASK)
            irq_mask_ff <= pwdata[`IRQ_BITS-1:0];
      end
   end

   assign serial_data_out = serial_data_out_ff;
   assign sink_output = sink_ff;
   assign irq = irq_ff;
   assign prdata = prdata_ff;
   assign pready = pready_ff;
   assign pslverr = pslverr_ff;

endmodule // led_fault_status_readout

// ### verilog/pin_sync.v
`timescale 1ns/100ps
`include "led_fault_defs.vh"

// ****************************************************************
// two-stage synchroniser with rising edge detect
// ****************************************************************
module pin_sync #(
   parameter WIDTH = 1
) (
   input wire ref_clk,
   input wire resetn,
   input wire [WIDTH-1:0] pin_in,
   output wire [WIDTH-1:0] level,
   output wire [WIDTH-1:0] rise
);

   reg [WIDTH-1:0] meta_ff;
   reg [WIDTH-1:0] sync_ff;
   reg [WIDTH-1:0] prev_ff;

   // meta_ff feeds sync_ff only; edges are found one stage later
   always @(posedge ref_clk) begin
      if (!resetn) begin
         meta_ff <= {WIDTH{1'b0}};
         sync_ff <= {WIDTH{1'b0}};
         prev_ff <= {WIDTH{1'b0}};
      end else begin
         meta_ff <= pin_in;
         sync_ff <= meta_ff;
         prev_ff <= sync_ff;
      end
   end

   assign level = sync_ff;
   assign rise = sync_ff & ~prev_ff;

endmodule // pin_sync
